// ==== aoc_consts.svh ====
// Purpose: timing counts, widths and codes for the converter output control block
// Assumes: system clock of 25 MHz (40 ns)
// Notes: times are kept in ns; cycle counts derive from them
`ifndef AOC_CONSTS_SVH
`define AOC_CONSTS_SVH

`define AOC_CLK_PERIOD_NS 40
`define AOC_DATA_W 14
`define AOC_PAIRS 7
// wake-up limits, longest times so counts round down
`define AOC_WAKE_SLOW_NS 50000
`define AOC_WAKE_DIFF_NS 500
`define AOC_WAKE_SE_NS 200
`define AOC_SETTLE_NS 1000000
`define AOC_WAKE_SLOW_CYC (`AOC_WAKE_SLOW_NS / `AOC_CLK_PERIOD_NS)
`define AOC_WAKE_DIFF_CYC (`AOC_WAKE_DIFF_NS / `AOC_CLK_PERIOD_NS)
`define AOC_WAKE_SE_CYC (`AOC_WAKE_SE_NS / `AOC_CLK_PERIOD_NS)
`define AOC_SETTLE_CYC (`AOC_SETTLE_NS / `AOC_CLK_PERIOD_NS)
// sample period above 1000 ns (below 1 MSPS) means clock stopped
`define AOC_STOP_NS 1000
`define AOC_STOP_CYC (`AOC_STOP_NS / `AOC_CLK_PERIOD_NS)
`define AOC_WAKE_W 11
`define AOC_SETTLE_W 16
`define AOC_GAP_W 6
// differential current codes in 0.25 mA units
`define AOC_CUR_3P5 6'h0E
`define AOC_CUR_2P5 6'h0A
`define AOC_CUR_4P5 6'h12
`define AOC_CUR_1P75 6'h07
// bit positions of levels crossing into the link domain
`define AOC_LX_OFF 0
`define AOC_LX_DDR 1
`define AOC_LX_VALID 2
`define AOC_LX_BUF 3

`endif

// ==== aoc_pkg.sv ====
// Purpose: types for the converter output control block
// Assumes: constants come from aoc_consts.svh
// Notes: power mode encoding is {buffer_off, standby}
`include "aoc_consts.svh"

package aoc_pkg;

  typedef enum logic [1:0] {
    AOC_NORMAL = 2'h0,
    AOC_STANDBY = 2'h1,
    AOC_OBUF_OFF = 2'h2,
    AOC_GLOBAL = 2'h3
  } aoc_mode_t;

  // gray along down -> wake -> run
  typedef enum logic [1:0] {
    AOC_RUN = 2'h0,
    AOC_WAKE = 2'h1,
    AOC_DOWN = 2'h3
  } aoc_pwr_st_t;

  typedef struct packed {
    logic pin_ctrl;
    logic obuf_off;
    logic standby;
    logic ddr_sel;
    logic offset_sel;
    logic output_clock_delay_bit;
    logic strong_drive;
    logic [1:0] current_sel;
    logic current_double;
    logic [2:0] data_term;
    logic [2:0] clock_pair_termination;
  } aoc_cfg_t;

  typedef struct packed {
    logic core_on;
    logic ref_on;
    logic strong_drive;
    logic clock_delay;
    logic [5:0] current_code;
    logic [2:0] data_term;
    logic [2:0] clock_pair_termination;
  } aoc_analog_t;

endpackage

// ==== aoc_core.sv ====
// Purpose: power-down control and output formatting of a 14-bit converter
// Assumes: link_clk_i runs at twice the sample rate; sample_i is on link_clk_i
// Notes: control on sys_clk_i, pin drive on link_clk_i
//
// How it works
// - power state comes from config bits or two synchronised control pins.
// - decode {buffer_off, standby}: normal, standby, buffers off, global down.
// - global down kills core, references, buffers; valid in 50 us, settled 1 ms.
// - standby powers down only the core; valid again within 50 us.
// - buffers off means high impedance; valid in 500 ns diff, 200 ns single.
// - sample rate below 1 MSPS enters clock stop; valid 50 us after return.
// - 14 bits plus output clock; single-ended or DDR chosen by bit or pin.
// - single-ended mode drives each bit on its own pin, once per sample.
// - delay bit moves output clock later, about 400 ps more setup.
// - stronger single-ended drive selectable for loads above 5 pF.
// - DDR mode muxes two bits per pair per cycle, 7 data pairs.
// - even bits launch on output clock rise, odd bits on its fall.
// - current field defaults 3.5 mA; also 2.5, 4.5 and 1.75 mA.
// - current double bit doubles data and clock pair current.
// - termination is any combination of three parallel resistors, eight settings.
// - data pairs and clock pair have separate termination fields.
// - output format two's complement or offset binary, by pin or bit.
`timescale 1ns/1ps
`default_nettype none
`include "aoc_consts.svh"

module aoc_core #(
  parameter int SETTLE_CYC = `AOC_SETTLE_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire aoc_pkg::aoc_cfg_t cfg_i,
  input wire logic serial_in_control_pin_i,
  input wire logic power_down_pin_i,
  input wire logic format_select_pin_i,
  input wire logic [`AOC_DATA_W-1:0] sample_i,
  output aoc_pkg::aoc_mode_t mode_o,
  output aoc_pkg::aoc_analog_t ana_o,
  output logic data_valid_o,
  output logic perf_settled_o,
  output logic clock_stopped_o,
  output logic [`AOC_DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic output_clock_o,
  output logic ddr_active_o
);

  localparam int WAKE_SLOW = `AOC_WAKE_SLOW_CYC;
  localparam int WAKE_DIFF = `AOC_WAKE_DIFF_CYC;
  localparam int WAKE_SE = `AOC_WAKE_SE_CYC;
  localparam int STOP_CYC = `AOC_STOP_CYC;

  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] tog_s;
    logic [`AOC_GAP_W-1:0] gap;
    logic stopped;
    aoc_pkg::aoc_pwr_st_t st;
    logic slow;
    logic [`AOC_WAKE_W-1:0] wake;
    logic [`AOC_SETTLE_W-1:0] settle;
    aoc_pkg::aoc_mode_t mode;
    logic ddr;
    logic offset;
    logic buf_en;
    logic valid;
    logic settled;
    aoc_pkg::aoc_analog_t ana;
  } aoc_sys_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic phase;
    logic [`AOC_DATA_W-1:0] word;
    logic [`AOC_DATA_W-1:0] dout;
    logic oe;
    logic clk;
    logic tog;
  } aoc_link_t;

  aoc_sys_t s;
  aoc_sys_t next_s;
  aoc_link_t l;
  aoc_link_t next_l;
  logic [1:0] link_rst_s;
  logic link_rst;

  ////////////////////////////////////////////////////////////////////////////
  // system domain: power control

  always_comb
  begin
    logic obuf;
    logic stby;
    logic edge_seen;
    logic down_cause;
    logic [5:0] cur;
    obuf = 1'b0;
    stby = 1'b0;
    edge_seen = 1'b0;
    down_cause = 1'b0;
    cur = `AOC_CUR_3P5;
    next_s = s;
    // pins: {format, serial_in, power_down}, two flops before use
    next_s.pin_s1 = {format_select_pin_i, serial_in_control_pin_i, power_down_pin_i};
    next_s.pin_s2 = s.pin_s1;
    next_s.tog_s = {s.tog_s[1:0], l.tog};
    edge_seen = s.tog_s[2] ^ s.tog_s[1];

    obuf = cfg_i.pin_ctrl ? s.pin_s2[1] : cfg_i.obuf_off;
    stby = cfg_i.pin_ctrl ? s.pin_s2[0] : cfg_i.standby;
    next_s.ddr = cfg_i.pin_ctrl ? s.pin_s2[2] : cfg_i.ddr_sel;
    next_s.offset = cfg_i.pin_ctrl ? s.pin_s2[2] : cfg_i.offset_sel;
    next_s.mode = aoc_pkg::aoc_mode_t'({obuf, stby});

    next_s.stopped = !edge_seen && (s.stopped || (s.gap >= `AOC_GAP_W'(STOP_CYC)));
    next_s.gap = edge_seen ? `AOC_GAP_W'(0)
      : ((s.gap >= `AOC_GAP_W'(STOP_CYC)) ? s.gap : s.gap + `AOC_GAP_W'(1));

    down_cause = (next_s.mode != aoc_pkg::AOC_NORMAL) || next_s.stopped;
    case (s.st)
      aoc_pkg::AOC_RUN:
      begin
        if (down_cause)
        begin
          next_s.st = aoc_pkg::AOC_DOWN;
          next_s.slow = 1'b0;
        end
      end
      aoc_pkg::AOC_DOWN:
      begin
        if (!down_cause)
        begin
          next_s.st = aoc_pkg::AOC_WAKE;
          next_s.wake = s.slow ? `AOC_WAKE_W'(WAKE_SLOW)
            : (next_s.ddr ? `AOC_WAKE_W'(WAKE_DIFF) : `AOC_WAKE_W'(WAKE_SE));
        end
      end
      aoc_pkg::AOC_WAKE:
      begin
        if (down_cause)
        begin
          next_s.st = aoc_pkg::AOC_DOWN;
        end
        else if (s.wake <= `AOC_WAKE_W'(1))
        begin
          next_s.st = aoc_pkg::AOC_RUN;
          next_s.wake = '0;
        end
        else
        begin
          next_s.wake = s.wake - `AOC_WAKE_W'(1);
        end
      end
      default:
      begin
        next_s.st = aoc_pkg::AOC_DOWN;
      end
    endcase
    if (next_s.st == aoc_pkg::AOC_DOWN && (next_s.stopped || next_s.mode[0]))
    begin
      next_s.slow = 1'b1;
    end

    next_s.ana.core_on = !next_s.mode[0] && !next_s.stopped;
    next_s.ana.ref_on = next_s.mode != aoc_pkg::AOC_GLOBAL;
    next_s.buf_en = !next_s.mode[1];
    next_s.valid = next_s.st == aoc_pkg::AOC_RUN;

    if (!next_s.ana.ref_on)
    begin
      next_s.settle = `AOC_SETTLE_W'(SETTLE_CYC);
    end
    else if (s.settle != '0)
    begin
      next_s.settle = s.settle - `AOC_SETTLE_W'(1);
    end
    next_s.settled = next_s.ana.ref_on && (next_s.settle == '0);

    case (cfg_i.current_sel)
      2'h0: cur = `AOC_CUR_3P5;
      2'h1: cur = `AOC_CUR_2P5;
      2'h2: cur = `AOC_CUR_4P5;
      2'h3: cur = `AOC_CUR_1P75;
      default: cur = `AOC_CUR_3P5;
    endcase
    next_s.ana.current_code = cfg_i.current_double ? {cur[4:0], 1'b0} : cur;
    next_s.ana.strong_drive = cfg_i.strong_drive;
    next_s.ana.clock_delay = cfg_i.output_clock_delay_bit;
    next_s.ana.data_term = cfg_i.data_term;
    next_s.ana.clock_pair_termination = cfg_i.clock_pair_termination;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.st <= aoc_pkg::AOC_DOWN;
      s.slow <= 1'b1;
      s.mode <= aoc_pkg::AOC_NORMAL;
      s.settle <= `AOC_SETTLE_W'(SETTLE_CYC);
      s.ana.current_code <= `AOC_CUR_3P5;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign mode_o = s.mode;
  assign ana_o = s.ana;
  assign data_valid_o = s.valid;
  assign perf_settled_o = s.settled;
  assign clock_stopped_o = s.stopped;

  ////////////////////////////////////////////////////////////////////////////
  // link domain: pin drive

  always_ff @(posedge link_clk_i)
  begin
    link_rst_s <= {link_rst_s[0], rst_i};
  end
  assign link_rst = link_rst_s[1];

  always_comb
  begin
    logic [`AOC_DATA_W-1:0] fmt;
    fmt = '0;
    next_l = l;
    next_l.s1 = {s.buf_en, s.valid, s.ddr, s.offset};
    next_l.s2 = l.s1;
    next_l.phase = !l.phase;
    next_l.oe = l.s2[`AOC_LX_BUF];
    fmt = sample_i ^ {l.s2[`AOC_LX_OFF], {(`AOC_DATA_W-1){1'b0}}};
    if (!l.phase)
    begin
      next_l.word = fmt;
      next_l.tog = !l.tog;
    end
    next_l.dout = '0;
    if (l.s2[`AOC_LX_DDR])
    begin
      // even bits with rise, odd with fall
      next_l.clk = !l.phase;
      for (int i = 0; i < `AOC_PAIRS; i++)
      begin
        next_l.dout[i] = l.phase ? l.word[2*i+1] : fmt[2*i];
      end
    end
    else
    begin
      next_l.clk = l.phase;
      next_l.dout = l.phase ? l.dout : fmt;
    end
    if (!l.s2[`AOC_LX_VALID])
    begin
      next_l.dout = '0;
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    if (link_rst)
    begin
      l <= '0;
    end
    else
    begin
      l <= next_l;
    end
  end

  assign data_o = l.dout;
  assign data_oe_o = l.oe;
  assign output_clock_o = l.clk;
  assign ddr_active_o = l.s2[`AOC_LX_DDR];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  global_down_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.mode == aoc_pkg::AOC_GLOBAL |-> !s.ana.core_on && !s.ana.ref_on && !s.buf_en && !s.settled)
    else $error("global power down left something on");

  standby_core_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.mode == aoc_pkg::AOC_STANDBY |-> !s.ana.core_on && s.ana.ref_on && s.buf_en && !s.valid)
    else $error("standby powered the wrong parts");

  obuf_hiz_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.mode == aoc_pkg::AOC_OBUF_OFF |-> !s.buf_en && s.ana.core_on == !s.stopped)
    else $error("buffer disable not high impedance");

  slow_wake_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(s.st) == aoc_pkg::AOC_DOWN && s.st == aoc_pkg::AOC_WAKE && $past(s.slow)
    |-> s.wake == `AOC_WAKE_W'(WAKE_SLOW))
    else $error("slow wake count wrong");

  fast_wake_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    $past(s.st) == aoc_pkg::AOC_DOWN && s.st == aoc_pkg::AOC_WAKE && !$past(s.slow)
    |-> s.wake == (s.ddr ? `AOC_WAKE_W'(WAKE_DIFF) : `AOC_WAKE_W'(WAKE_SE)))
    else $error("fast wake count wrong");

  valid_run_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.valid |-> s.st == aoc_pkg::AOC_RUN && s.mode == aoc_pkg::AOC_NORMAL && !s.stopped)
    else $error("valid outside normal operation");

  clock_stop_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s.gap >= `AOC_GAP_W'(STOP_CYC) && s.tog_s[2] == s.tog_s[1] |=> s.stopped && !s.ana.core_on)
    else $error("stopped clock not detected");

  se_format_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    l.s2[`AOC_LX_VALID] && !l.s2[`AOC_LX_DDR] && !l.phase ##1 !l.s2[`AOC_LX_DDR]
    |-> l.dout == ($past(sample_i) ^ {$past(l.s2[`AOC_LX_OFF]), 13'h0000}) && !l.clk ##1 l.clk)
    else $error("single-ended word or format wrong");

  ddr_order_a: assert property (@(posedge link_clk_i) disable iff (link_rst)
    l.s2[`AOC_LX_VALID] && l.s2[`AOC_LX_DDR] && !l.phase ##1 l.s2[`AOC_LX_DDR]
    |-> l.clk && l.dout[0] == l.word[0] ##1 (!l.clk && l.dout[0] == (l.word[1] && $past(l.s2[`AOC_LX_VALID]))
    && l.dout[6] == (l.word[13] && $past(l.s2[`AOC_LX_VALID]))))
    else $error("ddr bit order wrong");

  global_cov_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    s.mode == aoc_pkg::AOC_GLOBAL ##1 s.st == aoc_pkg::AOC_WAKE);
  wake_run_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
    s.st == aoc_pkg::AOC_WAKE ##1 s.st == aoc_pkg::AOC_RUN);
  stop_cov_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) $rose(s.stopped));
  ddr_cov_c: cover property (@(posedge link_clk_i) disable iff (link_rst)
    l.s2[`AOC_LX_DDR] && l.s2[`AOC_LX_VALID] && l.clk);

endmodule
`default_nettype wire

// ==== aoc_rx_model.sv ====
// Purpose: receiver model capturing converter output words
// Assumes: ddr_i matches the interface the converter is set to
// Notes: captures 30 ns after each output clock edge in DDR, after the rising edge only in single-ended, as a delayed capture clock
`timescale 1ns/1ps
`default_nettype none

module aoc_rx_model (
  input wire logic ddr_i,
  input wire logic output_clock_i,
  input wire logic oe_i,
  input wire logic [13:0] data_i,
  output logic [13:0] word_o
);
  logic [6:0] even;

  initial
  begin
    word_o = 14'h0000;
    even = 7'h00;
  end

  ////////////////////////////////////////
  // latch on rise
  always @(posedge output_clock_i)
  begin
    #30;
    if (oe_i && ddr_i)
      even = data_i[6:0];
    else if (oe_i)
      word_o = data_i;
  end

  always @(negedge output_clock_i)
  begin
    #30;
    if (oe_i && ddr_i)
      for (int i = 0; i < 7; i++)
      begin
        word_o[2*i] = even[i];
        word_o[2*i+1] = data_i[i];
      end
  end
endmodule

`default_nettype wire

// ==== aoc_core_tb.sv ====
// Purpose: self-checking bench for the converter output control block
// Assumes: settle count shortened to 50 cycles
// Notes: link clock is gated to model a stopped sample clock
`timescale 1ns/1ps
`default_nettype none
`include "aoc_consts.svh"

module aoc_core_tb;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic link_run = 1'b1;
  logic rst = 1'b1;
  aoc_pkg::aoc_cfg_t cfg = '0;
  logic ctl_pin = 1'b0;
  logic pd_pin = 1'b0;
  logic fmt_pin = 1'b0;
  logic rx_ddr = 1'b0;
  logic [13:0] sample = 14'h0000;
  aoc_pkg::aoc_mode_t mode;
  aoc_pkg::aoc_analog_t ana;
  logic valid, settled, stopped, oe, oclk, ddr_act;
  logic [13:0] data, rx_word;
  logic [5:0] base [4];
  logic [31:0] mask = 32'h0000_0000;
  int num_errors = 0;
  int total_checks = 0;

  always #20 sys_clk = ~sys_clk;
  always #62.5 link_clk = link_run ? ~link_clk : 1'b0;

  aoc_core #(.SETTLE_CYC(50)) i_aoc_core (
    .sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk), .cfg_i(cfg),
    .serial_in_control_pin_i(ctl_pin), .power_down_pin_i(pd_pin), .format_select_pin_i(fmt_pin),
    .sample_i(sample), .mode_o(mode), .ana_o(ana), .data_valid_o(valid), .perf_settled_o(settled),
    .clock_stopped_o(stopped), .data_o(data), .data_oe_o(oe), .output_clock_o(oclk), .ddr_active_o(ddr_act)
  );

  aoc_rx_model i_aoc_rx_model (
    .ddr_i(rx_ddr), .output_clock_i(oclk), .oe_i(oe), .data_i(data), .word_o(rx_word)
  );

  ////////////////////////////////////////
  task end_sim;
    if (num_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // bounded wait for valid data, count must fall in lo..hi
  task wait_valid(input int lo, input int hi);
    int n;
    n = 0;
    while (valid !== 1'b1 && n <= hi)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask

  task run_data(input logic [13:0] w, input logic [13:0] e);
    @(negedge link_clk);
    sample = w;
    repeat (12) @(posedge link_clk);
    #40;
    chk(rx_word, e);
    @(negedge sys_clk);
  endtask

  ////////////////////////////////////////
  initial
  begin
    base = '{`AOC_CUR_3P5, `AOC_CUR_2P5, `AOC_CUR_4P5, `AOC_CUR_1P75};
    repeat (6) @(negedge sys_clk);
    chk(ana, 32'h0000_0380);
    chk({mode, valid, settled, stopped}, 32'h0000_0000);
    rst = 1'b0;
    wait_valid(1200, 1400);
    run_data(14'h2A5C, 14'h2A5C);
    cfg.offset_sel = 1'b1;
    run_data(14'h2A5C, 14'h0A5C);
    run_data(14'h1FFF, 14'h3FFF);
    cfg.offset_sel = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      cfg.current_sel = i[1:0];
      cfg.current_double = i[2];
      cfg.data_term = i[2:0];
      cfg.clock_pair_termination = 3'(7 - i);
      cfg.strong_drive = i[0];
      cfg.output_clock_delay_bit = i[1];
      cyc(2);
      if (i < 4)
      begin
        chk(ana.current_code, base[i]);
        mask = mask | (32'h0000_0001 << ana.current_code);
      end
      else
        chk(ana.current_code, {base[i-4], 1'b0});
      chk({ana.data_term, ana.clock_pair_termination}, {i[2:0], 3'(7 - i)});
      chk({ana.strong_drive, ana.clock_delay}, {i[0], i[1]});
    end
    chk(mask, 32'h0004_4480);
    chk(base[0], 32'h0000_000E);
    cfg = '0;
    for (int m = 0; m < 4; m++)
    begin
      {cfg.obuf_off, cfg.standby} = m[1:0];
      cyc(20);
      chk(mode, m);
      chk({ana.core_on, ana.ref_on}, {~m[0], m != 3});
      if (m > 1)
        chk(oe, 32'h0000_0000);
      if (m == 1)
        chk(data, 32'h0000_0000);
    end
    {cfg.obuf_off, cfg.standby} = 2'b00;
    cyc(30);
    chk(settled, 32'h0000_0000);
    cyc(30);
    chk(settled, 32'h0000_0001);
    wait_valid(1100, 1196);
    cfg.obuf_off = 1'b1;
    cyc(20);
    cfg.obuf_off = 1'b0;
    wait_valid(4, 7);
    cfg.ddr_sel = 1'b1;
    rx_ddr = 1'b1;
    cyc(20);
    chk(ddr_act, 32'h0000_0001);
    cfg.obuf_off = 1'b1;
    cyc(20);
    cfg.obuf_off = 1'b0;
    wait_valid(10, 14);
    run_data(14'h2A5C, 14'h2A5C);
    run_data(14'h1555, 14'h1555);
    cfg.offset_sel = 1'b1;
    run_data(14'h0001, 14'h2001);
    link_run = 1'b0;
    cyc(40);
    chk({stopped, valid}, 32'h0000_0002);
    link_run = 1'b1;
    wait_valid(1200, 1300);
    chk(stopped, 32'h0000_0000);
    cfg = '0;
    cfg.pin_ctrl = 1'b1;
    fmt_pin = 1'b1;
    cyc(20);
    chk(ddr_act, 32'h0000_0001);
    run_data(14'h1555, 14'h3555);
    fmt_pin = 1'b0;
    rx_ddr = 1'b0;
    cyc(20);
    chk(ddr_act, 32'h0000_0000);
    run_data(14'h1555, 14'h1555);
    for (int m = 3; m > 0; m--)
    begin
      {ctl_pin, pd_pin} = m[1:0];
      cyc(5);
      chk(mode, m);
    end
    end_sim;
  end

  // watchdog against a hung wait
  initial
  begin
    #400_000;
    num_errors++;
    end_sim;
  end
endmodule

`default_nettype wire
